/* rtl/clu_pkg.sv */
// constants, types and helpers shared by the configurable logic units
package clu_pkg;

   // ----------------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------------
   localparam int UNIT_COUNT   = 4;
   localparam int PERIPH_COUNT = 4;
   localparam int PIN_COUNT    = 8;
   localparam int SOURCE_COUNT = 16;

   // ----------------------------------------------------------------------
   // register map (8-bit special function register space)
   // ----------------------------------------------------------------------
   localparam logic [7:0] ADDR_UNIT0_INPUT_SELECT     = 8'h84;
   localparam logic [7:0] ADDR_UNIT_REG_STRIDE        = 8'h03;
   localparam logic [7:0] OFS_INPUT_SELECT            = 8'h00;
   localparam logic [7:0] OFS_FUNCTION                = 8'h01;
   localparam logic [7:0] OFS_CONFIGURATION           = 8'h02;
   localparam logic [7:0] ADDR_UNIT_ENABLE            = 8'hc6;
   localparam logic [7:0] ADDR_UNIT_INTERRUPT_ENABLE  = 8'hc7;
   localparam logic [7:0] ADDR_UNIT_OUTPUT_STATUS     = 8'hd1;
   localparam logic [7:0] ADDR_UNIT_EDGE_FLAGS        = 8'he8;

   // ----------------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------------
   localparam int SEL_A_LSB          = 0;
   localparam int SEL_B_LSB          = 4;
   localparam int CF_OUTPUT_SOURCE_SELECT_BIT      = 7;
   localparam int CF_FLOP_CLEAR_BIT  = 6;
   localparam int CF_PIN_OE_BIT      = 5;
   localparam int CF_CLK_INV_BIT     = 4;
   localparam int CF_CLK_SEL_LSB     = 0;
   localparam int FLAG_FALL_LSB      = 0;
   localparam int FLAG_RISE_LSB      = 4;

   // ----------------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------------
   localparam logic [7:0] RESET_BYTE = 8'h00;

   // ----------------------------------------------------------------------
   // types
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      CLK_FROM_CARRY,
      CLK_FROM_A,
      CLK_FROM_SYSTEM,
      CLK_FROM_B
   } flop_clock_sel_t;

   typedef struct packed {
      logic [3:0]      b_input_select;
      logic [3:0]      a_input_select;
      logic [7:0]      function_select;
      logic            output_source_select;
      logic            flop_clock_invert;
      flop_clock_sel_t flop_clock_select;
   } unit_cfg_t;

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   function automatic logic lut_lookup(input logic [7:0] fn,
                                       input logic a,
                                       input logic b,
                                       input logic c);
      logic [2:0] idx;
      idx = {a, b, c};
      return fn[idx];
   endfunction

   function automatic logic [7:0] unit_reg_addr(input int unsigned unit,
                                                input logic [7:0] ofs);
      logic [7:0] u;
      u = 8'(unit);
      return 8'(ADDR_UNIT0_INPUT_SELECT + u * ADDR_UNIT_REG_STRIDE + ofs);
   endfunction

endpackage

/* rtl/logic_unit.sv */
// one configurable logic unit: input muxes, lookup table, d flip-flop
`timescale 1ns/100ps
`default_nettype none

module logic_unit
   import clu_pkg::*;
(
   input  wire logic                    clk_sys,
   input  wire logic                    reset,
   input  wire unit_cfg_t               cfg,
   input  wire logic                    unit_enable_bit,
   input  wire logic [SOURCE_COUNT-1:0] source_bus,
   input  wire logic                    carry_in,
   input  wire logic                    flop_clear,
   output logic                         lut_out,
   output logic                         async_out
);

   logic a_in;
   logic b_in;
   logic clk_src;
   logic clk_src_prev_reg;
   logic flop_tick;
   logic flop_reg;

   // ----------------------------------------------------------------------
   // inputs and table
   // ----------------------------------------------------------------------
   assign a_in    = source_bus[cfg.a_input_select];
   assign b_in    = source_bus[cfg.b_input_select];
   assign lut_out = lut_lookup(cfg.function_select, a_in, b_in,
                               carry_in);

   // ----------------------------------------------------------------------
   // flip-flop clocking
   // ----------------------------------------------------------------------
   // single clock design: the chosen source is sampled and its edge used
   // as an enable, so a non-system source adds no cycle of lag
   always_comb
   begin
      case (cfg.flop_clock_select)
         CLK_FROM_CARRY: clk_src = carry_in;
         CLK_FROM_A:     clk_src = a_in;
         CLK_FROM_B:     clk_src = b_in;
         default:        clk_src = 1'b0;
      endcase
      clk_src = clk_src ^ cfg.flop_clock_invert;
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         clk_src_prev_reg <= 1'b0;
      else
         clk_src_prev_reg <= clk_src;
   end

   assign flop_tick = (cfg.flop_clock_select == CLK_FROM_SYSTEM) ||
                      (clk_src && !clk_src_prev_reg);

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         flop_reg <= 1'b0;
      else if (flop_clear)
         flop_reg <= 1'b0;
      else if (flop_tick)
         flop_reg <= lut_out;
   end

   // ----------------------------------------------------------------------
   // output
   // ----------------------------------------------------------------------
   assign async_out = unit_enable_bit &&
                      (cfg.output_source_select ?
                       flop_reg : lut_out);

endmodule

`default_nettype wire

/* rtl/configurable_logic_units.sv */
// four configurable logic units with their register file and pin outputs
`timescale 1ns/100ps
`default_nettype none

// How it works
// - four independent units, logic plus flip-flop
// - inputs A and B by select, carry C
// - unit-to-unit inputs use asynchronous outputs
// - carry is previous unit table output, ring
// - timer overflow input is one-cycle pulse
// - pins unsynchronized, peripherals already synchronous
// - asynchronous and synchronized outputs; status readable
// - output from table or flip-flop
// - disabled unit forces both outputs low
// - flip-flop clock picked from four sources
// - selected non-system flip-flop clock may be inverted
// - clear bit resets flip-flop, self-clearing
// - peripheral outputs synchronized, unit links not
// - table is eight-input mux over function
// - bits 7,6 for A=B=1; 2-5 differ
// - separate falling and rising interrupt enables
// - one enable bit per unit, together
// - pin driven only while pin enable set
// - asynchronous output usable as wake-up
module configurable_logic_units
   import clu_pkg::*;
(
   input  wire logic                    clk_sys,
   input  wire logic                    reset,
   input  wire logic [7:0]              sfr_addr,
   input  wire logic                    sfr_wr_en,
   input  wire logic                    sfr_rd_en,
   input  wire logic [7:0]              sfr_wdata,
   output logic [7:0]                   sfr_rdata,
   input  wire logic [PERIPH_COUNT-1:0] periph_in,
   input  wire logic [PIN_COUNT-1:0]    pin_in,
   output logic [UNIT_COUNT-1:0]        unit_async_out,
   output logic [UNIT_COUNT-1:0]        unit_sync_out,
   output logic [UNIT_COUNT-1:0]        unit_pin_out,
   output logic [UNIT_COUNT-1:0]        unit_pin_oe,
   output logic                         irq
);

   // ----------------------------------------------------------------------
   // register file state
   // ----------------------------------------------------------------------
   logic [7:0]            input_select_reg [UNIT_COUNT];
   logic [7:0]            function_reg     [UNIT_COUNT];
   logic [7:0]            config_reg       [UNIT_COUNT];
   logic [UNIT_COUNT-1:0] flop_clear_reg;
   logic [7:0]            unit_enable_reg;
   logic [7:0]            unit_enable_next;
   logic [7:0]            interrupt_enable_reg;
   logic [7:0]            edge_flags_reg;
   logic [7:0]            edge_flags_next;
   logic [7:0]            rdata_reg;
   logic [7:0]            rdata_next;

   // ----------------------------------------------------------------------
   // unit datapath signals
   // ----------------------------------------------------------------------
   unit_cfg_t                cfg        [UNIT_COUNT];
   logic [UNIT_COUNT-1:0]    lut_out;
   logic [UNIT_COUNT-1:0]    async_out;
   logic [UNIT_COUNT-1:0]    sync_reg;
   logic [UNIT_COUNT-1:0]    sync_next;
   logic [UNIT_COUNT-1:0]    pin_out_reg;
   logic [UNIT_COUNT-1:0]    pin_oe_reg;
   logic [UNIT_COUNT-1:0]    rise_set;
   logic [UNIT_COUNT-1:0]    fall_set;
   logic [SOURCE_COUNT-1:0]  source_bus;
   logic                     irq_reg;

   // ----------------------------------------------------------------------
   // input source bus
   // ----------------------------------------------------------------------
   // unit links take the unsynchronized outputs so cascades settle
   // within one pass; pins enter raw, peripherals are already on clk_sys
   assign source_bus = {pin_in,
                        periph_in,
                        async_out};

   // ----------------------------------------------------------------------
   // units
   // ----------------------------------------------------------------------
   for (genvar i = 0; i < UNIT_COUNT; i++)
   begin : g_unit
      localparam int PREV = (i + UNIT_COUNT - 1) % UNIT_COUNT;
      always_comb
      begin
         cfg[i].a_input_select       = input_select_reg[i][SEL_A_LSB +: 4];
         cfg[i].b_input_select       = input_select_reg[i][SEL_B_LSB +: 4];
         cfg[i].function_select      = function_reg[i];
         cfg[i].output_source_select = config_reg[i][CF_OUTPUT_SOURCE_SELECT_BIT];
         cfg[i].flop_clock_invert    = config_reg[i][CF_CLK_INV_BIT];
         cfg[i].flop_clock_select    =
            flop_clock_sel_t'(config_reg[i][CF_CLK_SEL_LSB +: 2]);
      end

      logic_unit u_unit
      (
         .clk_sys         (clk_sys),
         .reset           (reset),
         .cfg             (cfg[i]),
         .unit_enable_bit (unit_enable_reg[i]),
         .source_bus      (source_bus),
         .carry_in        (lut_out[PREV]),
         .flop_clear      (flop_clear_reg[i]),
         .lut_out         (lut_out[i]),
         .async_out       (async_out[i])
      );
   end

   // the asynchronous outputs leave without a flip-flop on purpose: they
   // must keep working as wake-up sources while clk_sys is stopped
   assign unit_async_out = async_out;

   // ----------------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      for (int i = 0; i < UNIT_COUNT; i++)
      begin
         if (reset)
         begin
            input_select_reg[i] <= RESET_BYTE;
            function_reg[i]     <= RESET_BYTE;
            config_reg[i]       <= RESET_BYTE;
         end
         else if (sfr_wr_en)
         begin
            if (sfr_addr == unit_reg_addr(i, OFS_INPUT_SELECT))
               input_select_reg[i] <= sfr_wdata;
            if (sfr_addr == unit_reg_addr(i, OFS_FUNCTION))
               function_reg[i] <= sfr_wdata;
            if (sfr_addr == unit_reg_addr(i, OFS_CONFIGURATION))
            begin
               config_reg[i] <= sfr_wdata;
               // the clear bit is an action, never stored
               config_reg[i][CF_FLOP_CLEAR_BIT] <= 1'b0;
            end
         end
      end
   end

   // one-cycle clear pulse per unit
   always_ff @(posedge clk_sys)
   begin
      for (int i = 0; i < UNIT_COUNT; i++)
      begin
         if (reset)
            flop_clear_reg[i] <= 1'b0;
         else
            flop_clear_reg[i] <= sfr_wr_en &&
               (sfr_addr == unit_reg_addr(i, OFS_CONFIGURATION)) &&
               sfr_wdata[CF_FLOP_CLEAR_BIT];
      end
   end

   // ----------------------------------------------------------------------
   // enables
   // ----------------------------------------------------------------------
   always_comb
   begin
      unit_enable_next = unit_enable_reg;
      if (sfr_wr_en && sfr_addr == ADDR_UNIT_ENABLE)
         unit_enable_next = sfr_wdata;
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         unit_enable_reg <= RESET_BYTE;
      else
         unit_enable_reg <= unit_enable_next;
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         interrupt_enable_reg <= RESET_BYTE;
      else if (sfr_wr_en && sfr_addr == ADDR_UNIT_INTERRUPT_ENABLE)
         interrupt_enable_reg <= sfr_wdata;
   end

   // ----------------------------------------------------------------------
   // synchronized outputs and pins
   // ----------------------------------------------------------------------
   // gating by the next enable makes the synchronized copy drop in the
   // same edge that disables the unit
   assign sync_next = async_out &
                      unit_enable_next[UNIT_COUNT-1:0];

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         sync_reg <= '0;
      else
         sync_reg <= sync_next;
   end

   assign unit_sync_out = sync_reg;

   always_ff @(posedge clk_sys)
   begin
      for (int i = 0; i < UNIT_COUNT; i++)
      begin
         if (reset)
         begin
            pin_out_reg[i] <= 1'b0;
            pin_oe_reg[i]  <= 1'b0;
         end
         else
         begin
            pin_out_reg[i] <= sync_next[i] &&
                              config_reg[i][CF_PIN_OE_BIT];
            pin_oe_reg[i]  <= config_reg[i][CF_PIN_OE_BIT];
         end
      end
   end

   assign unit_pin_out = pin_out_reg;
   assign unit_pin_oe  = pin_oe_reg;

   // ----------------------------------------------------------------------
   // edge flags and interrupt request
   // ----------------------------------------------------------------------
   assign rise_set = sync_next & ~sync_reg & unit_enable_reg[UNIT_COUNT-1:0];
   assign fall_set = ~sync_next & sync_reg & unit_enable_reg[UNIT_COUNT-1:0];

   always_comb
   begin
      edge_flags_next = edge_flags_reg;
      if (sfr_wr_en && sfr_addr == ADDR_UNIT_EDGE_FLAGS)
         edge_flags_next = sfr_wdata;
      // a new edge beats a software clear in the same cycle
      edge_flags_next[FLAG_FALL_LSB +: UNIT_COUNT] =
         edge_flags_next[FLAG_FALL_LSB +: UNIT_COUNT] | fall_set;
      edge_flags_next[FLAG_RISE_LSB +: UNIT_COUNT] =
         edge_flags_next[FLAG_RISE_LSB +: UNIT_COUNT] | rise_set;
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         edge_flags_reg <= RESET_BYTE;
      else
         edge_flags_reg <= edge_flags_next;
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         irq_reg <= 1'b0;
      else
         irq_reg <= |(edge_flags_next & interrupt_enable_reg);
   end

   assign irq = irq_reg;

   // ----------------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------------
   always_comb
   begin
      rdata_next = RESET_BYTE;
      case (sfr_addr)
         ADDR_UNIT_ENABLE:           rdata_next = unit_enable_reg;
         ADDR_UNIT_INTERRUPT_ENABLE: rdata_next = interrupt_enable_reg;
         ADDR_UNIT_EDGE_FLAGS:       rdata_next = edge_flags_reg;
         ADDR_UNIT_OUTPUT_STATUS:
            rdata_next = {{(8-UNIT_COUNT){1'b0}}, sync_reg};
         default:
         begin
            for (int i = 0; i < UNIT_COUNT; i++)
            begin
               if (sfr_addr == unit_reg_addr(i, OFS_INPUT_SELECT))
                  rdata_next = input_select_reg[i];
               if (sfr_addr == unit_reg_addr(i, OFS_FUNCTION))
                  rdata_next = function_reg[i];
               if (sfr_addr == unit_reg_addr(i, OFS_CONFIGURATION))
                  rdata_next = config_reg[i];
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         rdata_reg <= RESET_BYTE;
      else if (sfr_rd_en)
         rdata_reg <= rdata_next;
   end

   assign sfr_rdata = rdata_reg;

endmodule

`default_nettype wire

/* dv/clu_props.sv */
// concurrent checks on the ports of the configurable logic units
`timescale 1ns/100ps
`default_nettype none
module clu_props
   import clu_pkg::*;
(
   input wire logic                  clk_sys,
   input wire logic                  reset,
   input wire logic [7:0]            sfr_addr,
   input wire logic                  sfr_wr_en,
   input wire logic                  sfr_rd_en,
   input wire logic [7:0]            sfr_wdata,
   input wire logic [7:0]            sfr_rdata,
   input wire logic [UNIT_COUNT-1:0] unit_async_out,
   input wire logic [UNIT_COUNT-1:0] unit_sync_out,
   input wire logic [UNIT_COUNT-1:0] unit_pin_out,
   input wire logic [UNIT_COUNT-1:0] unit_pin_oe,
   input wire logic                  irq
);
   // ----
   // enable shadow, rebuilt from bus writes
   // ----
   logic [3:0] en_shadow;
   always_ff @(posedge clk_sys)
   begin
      if (reset)
         en_shadow <= 4'h0;
      else if (sfr_wr_en && sfr_addr == ADDR_UNIT_ENABLE)
         en_shadow <= sfr_wdata[3:0];
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   // ----
   // properties
   // ----
   property p_off_low;
      ((unit_async_out | unit_sync_out) & ~en_shadow) == 4'h0;
   endproperty
   a_off_low: assert property (p_off_low)
      else $error("disabled unit output not low");
   property p_sync_follow;
      !sfr_wr_en |=> unit_sync_out == $past(unit_async_out);
   endproperty
   a_sync_follow: assert property (p_sync_follow)
      else $error("sync output does not follow async output");
   property p_sync_src;
      (unit_sync_out & ~$past(unit_async_out)) == 4'h0;
   endproperty
   a_sync_src: assert property (p_sync_src)
      else $error("sync output high without async cause");
   property p_status;
      sfr_rd_en && sfr_addr == ADDR_UNIT_OUTPUT_STATUS
         |=> sfr_rdata[3:0] == $past(unit_sync_out);
   endproperty
   a_status: assert property (p_status)
      else $error("status read differs from sync outputs");
   property p_pin_gate;
      (unit_pin_out & ~unit_pin_oe) == 4'h0;
   endproperty
   a_pin_gate: assert property (p_pin_gate)
      else $error("pin driven while its enable is low");
   property p_oe_by_write;
      $changed(unit_pin_oe) |-> $past(sfr_wr_en) || $past(sfr_wr_en, 2);
   endproperty
   a_oe_by_write: assert property (p_oe_by_write)
      else $error("pin enable changed without a write");
   property p_irq_rise;
      $rose(irq) |-> $past(sfr_wr_en) || $past(sfr_wr_en, 2)
         || unit_sync_out != $past(unit_sync_out)
         || $past(unit_sync_out) != $past(unit_sync_out, 2);
   endproperty
   a_irq_rise: assert property (p_irq_rise)
      else $error("interrupt raised without an edge");
   property p_irq_fall;
      $fell(irq) |-> $past(sfr_wr_en) || $past(sfr_wr_en, 2);
   endproperty
   a_irq_fall: assert property (p_irq_fall)
      else $error("interrupt dropped without a write");
endmodule
bind configurable_logic_units clu_props clu_props_i (.clk_sys, .reset,
   .sfr_addr, .sfr_wr_en, .sfr_rd_en, .sfr_wdata, .sfr_rdata,
   .unit_async_out, .unit_sync_out, .unit_pin_out, .unit_pin_oe, .irq);
`default_nettype wire

/* dv/periph_model.sv */
// timers and port pins that feed the logic units
`timescale 1ns/100ps
`default_nettype none
module periph_model
   import clu_pkg::*;
(
   input  wire logic                    clk_sys,
   input  wire logic                    reset,
   input  wire logic [PIN_COUNT-1:0]    pin_drive,
   output logic [PERIPH_COUNT-1:0]      periph_in,
   output logic [PIN_COUNT-1:0]         pin_in
);
   int cnt [PERIPH_COUNT];
   // ----
   // overflow pulses, periods 3 to 6 cycles
   // ----
   always_ff @(posedge clk_sys)
   begin
      for (int i = 0; i < PERIPH_COUNT; i++)
      begin
         if (reset || cnt[i] == i + 2)
            cnt[i] <= 0;
         else
            cnt[i] <= cnt[i] + 1;
         periph_in[i] <= !reset && cnt[i] == i + 2;
      end
   end
   // raw pins, no resync, so edges land anywhere in the cycle
   assign pin_in = pin_drive;
endmodule
`default_nettype wire

/* dv/test_configurable_logic_units.sv */
// self-checking bench for the configurable logic units
`timescale 1ns/100ps
`default_nettype none
module test_configurable_logic_units
   import clu_pkg::*;
;
   logic       clk_sys = 1'b0;
   logic       reset = 1'b1;
   logic [7:0] sfr_addr = 8'h00;
   logic [7:0] sfr_wdata = 8'h00;
   logic       sfr_wr_en = 1'b0;
   logic       sfr_rd_en = 1'b0;
   logic [7:0] pin_drive = 8'h00;
   logic [7:0] sfr_rdata;
   logic [7:0] pin_in;
   logic [3:0] periph_in, unit_async_out, unit_sync_out;
   logic [3:0] unit_pin_out, unit_pin_oe;
   logic       irq;
   logic [3:0] sel_a [4] = '{4{4'h4}};
   logic [3:0] sel_b [4] = '{4{4'h4}};
   logic [7:0] fn [4] = '{4{8'h00}};
   logic [7:0] cf [4] = '{4{8'h00}};
   logic [3:0] en = 4'h0;
   int         bad_count = 0;
   int         n_tests = 0;

   configurable_logic_units configurable_logic_units_i (.clk_sys, .reset,
      .sfr_addr, .sfr_wr_en, .sfr_rd_en, .sfr_wdata, .sfr_rdata,
      .periph_in, .pin_in, .unit_async_out, .unit_sync_out,
      .unit_pin_out, .unit_pin_oe, .irq);
   periph_model periph_model_i (.clk_sys, .reset, .pin_drive, .periph_in,
      .pin_in);

   always #10 clk_sys = ~clk_sys;

   // ----
   // helpers
   // ----
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] seen, exp);
      n_tests++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(posedge clk_sys);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr_en <= 1'b1;
      @(posedge clk_sys);
      sfr_wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, exp);
      @(posedge clk_sys);
      sfr_addr <= a;
      sfr_rd_en <= 1'b1;
      @(posedge clk_sys);
      sfr_rd_en <= 1'b0;
      @(negedge clk_sys);
      check("read data", sfr_rdata, exp);
   endtask
   task automatic set_unit(input int i, input logic [3:0] a, b,
                           input logic [7:0] f, c);
      logic [7:0] base;
      base = ADDR_UNIT0_INPUT_SELECT + 8'(3 * i);
      sel_a[i] = a;
      sel_b[i] = b;
      fn[i] = f;
      cf[i] = c;
      wr(base, {b, a});
      wr(base + 8'h01, f);
      wr(base + 8'h02, c);
   endtask
   // lut-mode model; unit 0 never reads carry, which cuts the ring
   function automatic logic [3:0] model_async();
      logic [15:0] src;
      logic [3:0]  lut;
      int          k;
      src = {pin_in, periph_in, 4'h0};
      lut = 4'h0;
      for (int i = 0; i < 4; i++)
      begin
         k = 4 * src[sel_a[i]] + 2 * src[sel_b[i]] + lut[(i + 3) % 4];
         lut[i] = fn[i][k];
         src[i] = lut[i] & en[i];
      end
      return src[3:0];
   endfunction
   task automatic watch(input int n);
      logic [3:0] prev, oe;
      oe = {cf[3][5], cf[2][5], cf[1][5], cf[0][5]};
      @(negedge clk_sys);
      prev = model_async();
      check("async", {4'h0, unit_async_out}, {4'h0, prev});
      repeat (n)
      begin
         @(negedge clk_sys);
         check("sync", {4'h0, unit_sync_out}, {4'h0, prev});
         check("pin",{unit_pin_oe,unit_pin_out},{oe,prev&oe});
         prev = model_async();
         check("async", {4'h0, unit_async_out}, {4'h0, prev});
      end
   endtask
   task automatic flop_step(input logic [7:0] p, input logic e);
      @(posedge clk_sys);
      pin_drive <= p;
      repeat (4) @(negedge clk_sys);
      check("flop", {7'h0, unit_async_out[0]}, {7'h0, e});
   endtask

   initial
   begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      report_and_stop();
   end

   // ----
   // main sequence
   // ----
   initial
   begin
      logic [31:0] r;
      logic [3:0]  a, b;
      logic [7:0]  f;
      void'($urandom(32'hbbb11069));
      repeat (10) @(posedge clk_sys);
      reset <= 1'b0;
      @(negedge clk_sys);
      check("outs", {unit_async_out, unit_sync_out}, 8'h00);
      for (int k = 0; k < 12; k++)
         rd(ADDR_UNIT0_INPUT_SELECT + 8'(k), 8'h00);
      rd(ADDR_UNIT_ENABLE, 8'h00);
      rd(ADDR_UNIT_INTERRUPT_ENABLE, 8'h00);
      rd(ADDR_UNIT_EDGE_FLAGS, 8'h00);
      for (int x = 0; x < 2; x++)
      begin
         set_unit(0, 4'h8, 4'h9, x ? 8'h3c : 8'hc0, 8'h00);
         en = 4'h1;
         wr(ADDR_UNIT_ENABLE, 8'h01);
         for (int p = 0; p < 4; p++)
         begin
            @(posedge clk_sys);
            pin_drive <= 8'(p);
            watch(2);
         end
      end
      for (int t = 0; t < 40; t++)
      begin
         for (int i = 0; i < 4; i++)
         begin
            r = $urandom;
            a = r[3:0];
            b = r[7:4];
            if (a < 4 && a >= i)
               a = a + 4'h4;
            if (b < 4 && b >= i)
               b = b + 4'h4;
            f = r[15:8];
            if (i == 0)
               f = {f[6], f[6], f[4], f[4], f[2], f[2], f[0], f[0]};
            set_unit(i, a, b, f, {2'b00, r[16], 5'h00});
         end
         r = $urandom;
         en = r[3:0];
         wr(ADDR_UNIT_ENABLE, {4'h0, en});
         pin_drive <= r[15:8];
         watch(12);
      end
      en = 4'h0;
      wr(ADDR_UNIT_ENABLE, 8'h00);
      set_unit(0, 4'h8, 4'h9, 8'hff, 8'h00);
      wr(ADDR_UNIT_EDGE_FLAGS, 8'h00);
      wr(ADDR_UNIT_INTERRUPT_ENABLE, 8'h10);
      en = 4'h1;
      wr(ADDR_UNIT_ENABLE, 8'h01);
      watch(3);
      check("irq", {7'h0, irq}, 8'h01);
      rd(ADDR_UNIT_EDGE_FLAGS, 8'h10);
      wr(ADDR_UNIT_INTERRUPT_ENABLE, 8'h01);
      watch(2);
      check("irq", {7'h0, irq}, 8'h00);
      en = 4'h0;
      wr(ADDR_UNIT_ENABLE, 8'h00);
      watch(3);
      check("irq", {7'h0, irq}, 8'h01);
      rd(ADDR_UNIT_EDGE_FLAGS, 8'h11);
      wr(ADDR_UNIT_EDGE_FLAGS, 8'h00);
      watch(2);
      check("irq", {7'h0, irq}, 8'h00);
      for (int i = 0; i < 4; i++)
         set_unit(i, 4'h8, 4'h9, 8'hff, 8'h00);
      en = 4'hf;
      wr(ADDR_UNIT_ENABLE, 8'h0f);
      watch(3);
      for (int i = 0; i < 4; i++)
         set_unit(i, 4'h8, 4'h9, 8'hff, 8'h20);
      watch(4);
      rd(ADDR_UNIT_OUTPUT_STATUS, 8'h0f);
      wr(ADDR_UNIT_OUTPUT_STATUS, 8'h00);
      rd(ADDR_UNIT_OUTPUT_STATUS, 8'h0f);
      rd(8'h00, 8'h00);
      // flop tests on unit 0, the others parked
      en = 4'h0;
      wr(ADDR_UNIT_ENABLE, 8'h00);
      pin_drive <= 8'h00;
      set_unit(0, 4'h8, 4'h9, 8'hcc, 8'hc1);
      en = 4'h1;
      wr(ADDR_UNIT_ENABLE, 8'h01);
      flop_step(8'h02, 1'b0);
      flop_step(8'h03, 1'b1);
      flop_step(8'h01, 1'b1);
      flop_step(8'h00, 1'b1);
      wr(ADDR_UNIT0_INPUT_SELECT + 8'h02, 8'hd1);
      rd(ADDR_UNIT0_INPUT_SELECT + 8'h02, 8'h91);
      flop_step(8'h02, 1'b0);
      flop_step(8'h03, 1'b0);
      flop_step(8'h02, 1'b1);
      wr(ADDR_UNIT0_INPUT_SELECT + 8'h02, 8'h82);
      flop_step(8'h00, 1'b0);
      flop_step(8'h02, 1'b1);
      // b input clocks the flop, table passes a
      wr(ADDR_UNIT0_INPUT_SELECT + 8'h01, 8'hf0);
      wr(ADDR_UNIT0_INPUT_SELECT + 8'h02, 8'h83);
      flop_step(8'h03, 1'b0);
      flop_step(8'h01, 1'b0);
      flop_step(8'h03, 1'b1);
      // carry clocks the flop: unit 3 table follows pin 2
      wr(ADDR_UNIT0_INPUT_SELECT + 8'h09, 8'h9a);
      wr(ADDR_UNIT0_INPUT_SELECT + 8'h0a, 8'hf0);
      wr(ADDR_UNIT0_INPUT_SELECT + 8'h02, 8'h80);
      flop_step(8'h00, 1'b1);
      flop_step(8'h04, 1'b0);
      report_and_stop();
   end
endmodule
`default_nettype wire
